// ===== hw/afp_top.sv
// Converter output formatting, bias and power control, register port.
// Assumes the analog sampler delivers a raw word with a valid pulse
// on the same clock and drives over/under flags with it.
`timescale 1ns/1ns
`default_nettype none
module afp_top (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Analog sampler interface
  input wire afp_pkg::afp_sample_t i_sample,
  output logic o_conv_start,
  output logic [10:0] o_integration_cycles,
  output logic [3:0] o_elem_count,
  // Bias and power controls
  output logic [1:0] o_amp_bias_level,
  output logic [1:0] o_adc_bias_level,
  output logic o_amp_enable,
  output logic o_adc_enable
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    afp_pkg::afp_state_t state;
    logic [15:0] result;
    logic [2:0] oversampling_code;
    logic [1:0] averaging_count_code;
    logic [1:0] amp_bias;
    logic [1:0] adc_bias;
    logic amp_en;
    logic adc_en;
    logic done;
    logic start;
    logic [7:0] rdata;
    logic [10:0] integration_cycles;
    logic [3:0] elem_count;
  } afp_regs_t;

  afp_regs_t st_reg;
  afp_regs_t st_next;
  logic [15:0] fmt_word;

  // Result formatting
  afp_formatter u_fmt (
    .i_sample(i_sample),
    .i_oversampling_code(st_reg.oversampling_code),
    .i_averaging_count_code(st_reg.averaging_count_code),
    .o_word(fmt_word)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.start = 1'b0;
    st_next.rdata = 8'h00;
    // Register writes
    if (i_wr) begin
      if (i_addr == afp_pkg::ADDR_CONFIG) begin
        st_next.oversampling_code =
          i_wdata[afp_pkg::CFG_OVERSAMPLE_LSB +: 3];
        st_next.averaging_count_code =
          i_wdata[afp_pkg::CFG_AVERAGE_LSB +: 2];
      end else if (i_addr == afp_pkg::ADDR_POWER) begin
        st_next.amp_bias = i_wdata[afp_pkg::PWR_AMP_BIAS_LSB +: 2];
        st_next.adc_bias = i_wdata[afp_pkg::PWR_ADC_BIAS_LSB +: 2];
        st_next.amp_en = i_wdata[afp_pkg::PWR_AMP_EN_BIT];
        st_next.adc_en = i_wdata[afp_pkg::PWR_ADC_EN_BIT];
      end else if (i_addr == afp_pkg::ADDR_CONTROL) begin
        if (i_wdata[afp_pkg::CTL_START_BIT]
            || i_wdata[afp_pkg::CTL_DEFAULT_START_BIT]) begin
          st_next.start = 1'b1;
          st_next.state = afp_pkg::ST_CONVERT;
          st_next.done = 1'b0;
        end
      end
    end
    // Oversampling and averaging counts for the sampler
    st_next.integration_cycles =
      11'h008 << st_next.oversampling_code;
    st_next.elem_count = 4'h1 << st_next.averaging_count_code;
    // Conversion sequencing
    case (st_reg.state)
      afp_pkg::ST_IDLE: begin
      end
      afp_pkg::ST_CONVERT: begin
        if (i_sample.valid && !st_next.start) begin
          st_next.result = fmt_word;
          st_next.done = 1'b1;
          st_next.state = afp_pkg::ST_DONE;
        end
      end
      afp_pkg::ST_DONE: begin
        if (!st_next.start) begin
          st_next.state = afp_pkg::ST_IDLE;
        end
      end
      default: begin
        st_next.state = afp_pkg::ST_IDLE;
      end
    endcase
    // Register reads, data one cycle later
    if (i_rd) begin
      if (i_addr == afp_pkg::ADDR_RESULT_HIGH) begin
        st_next.rdata = st_reg.result[15:8];
      end else if (i_addr == afp_pkg::ADDR_RESULT_LOW) begin
        st_next.rdata = st_reg.result[7:0];
      end else if (i_addr == afp_pkg::ADDR_CONFIG) begin
        st_next.rdata = {1'b0, st_reg.averaging_count_code,
                         st_reg.oversampling_code, 2'b00};
      end else if (i_addr == afp_pkg::ADDR_POWER) begin
        st_next.rdata = {2'b00, st_reg.adc_en, st_reg.amp_en,
                         st_reg.adc_bias, st_reg.amp_bias};
      end else if (i_addr == afp_pkg::ADDR_STATUS) begin
        st_next.rdata = {6'h00, st_reg.done,
                         st_reg.state == afp_pkg::ST_CONVERT};
      end else begin
        st_next.rdata = 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '{state: afp_pkg::ST_IDLE, result: 16'h0000,
                  oversampling_code: afp_pkg::OVERSAMPLE_CODE_RESET,
                  averaging_count_code: afp_pkg::AVERAGE_CODE_RESET,
                  amp_bias: afp_pkg::BIAS_RESET,
                  adc_bias: afp_pkg::BIAS_RESET,
                  amp_en: 1'b0, adc_en: 1'b0, done: 1'b0,
                  start: 1'b0, rdata: 8'h00,
                  integration_cycles: 11'h008, elem_count: 4'h1};
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops
  assign o_rdata = st_reg.rdata;
  assign o_conv_start = st_reg.start;
  assign o_integration_cycles = st_reg.integration_cycles;
  assign o_elem_count = st_reg.elem_count;
  assign o_amp_bias_level = st_reg.amp_bias;
  assign o_adc_bias_level = st_reg.adc_bias;
  assign o_amp_enable = st_reg.amp_en;
  assign o_adc_enable = st_reg.adc_en;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  sequence s_start_write;
    i_wr && i_addr == afp_pkg::ADDR_CONTROL && (i_wdata[1:0] != 2'b00);
  endsequence

  sequence s_sample_taken;
    st_reg.state == afp_pkg::ST_CONVERT && i_sample.valid && !st_next.start;
  endsequence

  a_start_pulse: assert property (s_start_write |=> o_conv_start
    ##1 !o_conv_start)
    else $error("start write did not pulse conversion start");
  a_start_busy: assert property (s_start_write |=>
    st_reg.state == afp_pkg::ST_CONVERT && !st_reg.done)
    else $error("start write did not enter converting state");
  // Lowest resolution keeps the six top bits, so only those are compared
  a_over_clamp: assert property (s_sample_taken and i_sample.over
    |=> st_reg.result[15:10] == 6'h1F)
    else $error("over-range not clamped positive");
  a_under_clamp: assert property (s_sample_taken and i_sample.under
    && !i_sample.over |=> st_reg.result[15:10] == 6'h20)
    else $error("under-range not clamped negative");
  a_low_pattern: assert property (s_sample_taken and
    st_reg.oversampling_code == 3'h0 && st_reg.averaging_count_code == 2'h3
    |=> st_reg.result[6:0] == 7'h40)
    else $error("forced low pattern wrong for resolution 9");
  a_full_res: assert property (s_sample_taken and
    st_reg.oversampling_code == 3'h7 && !i_sample.over && !i_sample.under
    |=> st_reg.result == $past(i_sample.value))
    else $error("full resolution result altered");
  // A capture may land on the read edge; the byte shown is the older one
  a_result_hi: assert property (i_rd
    && i_addr == afp_pkg::ADDR_RESULT_HIGH
    |=> o_rdata == $past(st_reg.result[15:8]))
    else $error("high result byte wrong");
  a_result_lo: assert property (i_rd
    && i_addr == afp_pkg::ADDR_RESULT_LOW
    |=> o_rdata == $past(st_reg.result[7:0]))
    else $error("low result byte wrong");
  a_power_off: assert property (i_wr && i_addr == 4'h3
    && !i_wdata[4] && !i_wdata[5] |=> !o_amp_enable && !o_adc_enable)
    else $error("stages not switched off");
  a_cycle_counts: assert property (i_wr && i_addr == 4'h2
    && i_wdata[4:2] == 3'h7 |=> o_integration_cycles == 11'h400
    && o_elem_count == (4'h1 << $past(i_wdata[6:5])))
    else $error("oversampling or averaging count wrong");
  a_bias_write: assert property (i_wr && i_addr == afp_pkg::ADDR_POWER
    |=> o_amp_bias_level == $past(i_wdata[1:0])
    && o_adc_bias_level == $past(i_wdata[3:2]))
    else $error("bias levels not taken from write");

endmodule
`default_nettype wire

// ===== hw/afp_pkg.sv
// Shared constants and carriers for the converter output/power block.
// Assumes a single 50 MHz clock domain and a plain register port.
package afp_pkg;

  // ----------------------------------------------------------------
  // Register map (word addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_RESULT_HIGH = 4'h0;
  localparam logic [3:0] ADDR_RESULT_LOW = 4'h1;
  localparam logic [3:0] ADDR_CONFIG = 4'h2;
  localparam logic [3:0] ADDR_POWER = 4'h3;
  localparam logic [3:0] ADDR_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_OVERSAMPLE_LSB = 2;
  localparam int CFG_AVERAGE_LSB = 5;
  localparam int PWR_AMP_BIAS_LSB = 0;
  localparam int PWR_ADC_BIAS_LSB = 2;
  localparam int PWR_AMP_EN_BIT = 4;
  localparam int PWR_ADC_EN_BIT = 5;
  localparam int CTL_START_BIT = 0;
  localparam int CTL_DEFAULT_START_BIT = 1;
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_DONE_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [2:0] OVERSAMPLE_CODE_RESET = 3'h0;
  localparam logic [1:0] AVERAGE_CODE_RESET = 2'h0;
  localparam logic [1:0] BIAS_RESET = 2'h3;
  localparam logic [15:0] FULL_SCALE_POS = 16'h7FFF;
  localparam logic [15:0] FULL_SCALE_NEG = 16'h8000;
  localparam int RESULT_BITS = 16;
  localparam int OVERSAMPLE_BASE_LOG2 = 3;
  localparam logic [4:0] RES_MAX = 5'h10;

  // Sampler handshake and raw conversion word
  typedef struct packed {
    logic valid;
    logic over;
    logic under;
    logic [15:0] value;
  } afp_sample_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONVERT = 2'b01,
    ST_DONE = 2'b10
  } afp_state_t;

endpackage

// ===== hw/afp_formatter.sv
// Result formatter: saturation and forced low-order pattern.
// Assumes raw value is a signed 16-bit word; purely combinational.
`timescale 1ns/1ns
`default_nettype none
module afp_formatter (
  // Raw sample and resolution settings
  input wire afp_pkg::afp_sample_t i_sample,
  input wire logic [2:0] i_oversampling_code,
  input wire logic [1:0] i_averaging_count_code,
  // Formatted word
  output logic [15:0] o_word
);

  logic [4:0] res;
  logic [4:0] nforce;
  logic [15:0] sat;
  logic [15:0] keep_mask;
  logic [15:0] pattern;

  // Resolution: twice log2 of ratio plus log2 of count, capped
  always_comb begin
    res = 5'((afp_pkg::OVERSAMPLE_BASE_LOG2
      + {2'h0, i_oversampling_code}) * 2)
      + {3'h0, i_averaging_count_code};
    if (res > afp_pkg::RES_MAX) begin
      res = afp_pkg::RES_MAX;
    end
    nforce = afp_pkg::RES_MAX - res;
  end

  // Clamp out-of-range input to nearest full scale
  always_comb begin
    if (i_sample.over) begin
      sat = afp_pkg::FULL_SCALE_POS;
    end else if (i_sample.under) begin
      sat = afp_pkg::FULL_SCALE_NEG;
    end else begin
      sat = i_sample.value;
    end
  end

  // One at top non-significant bit, zeros below
  always_comb begin
    keep_mask = 16'hFFFF << nforce;
    pattern = 16'h0000;
    if (nforce != 5'h00) begin
      pattern = 16'h0001 << (nforce - 5'h01);
    end
    o_word = (sat & keep_mask) | pattern;
  end

endmodule
`default_nettype wire

// ===== verification/afp_sampler_model.sv
// Sampler stand-in: answers each conversion start with one raw word.
// Assumes the bench sets word and range flags before the start.
`timescale 1ns/1ns
`default_nettype none
module afp_sampler_model (
  // Clock, reset and start
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_start,
  // Word to return
  input wire logic [15:0] i_value,
  input wire logic i_over,
  input wire logic i_under,
  // Sample to the block
  output var afp_pkg::afp_sample_t o_sample
);
  logic [2:0] cnt_reg;
  // Count down from start; valid pulses once at the end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= 3'h0;
    end else if (i_start) begin
      cnt_reg <= 3'h4;
    end else if (cnt_reg != 3'h0) begin
      cnt_reg <= cnt_reg - 3'h1;
    end
  end
  // Word only with valid; inverse otherwise so stale use shows up
  always_comb begin
    o_sample.valid = (cnt_reg == 3'h1);
    o_sample.value = o_sample.valid ? i_value : ~i_value;
    o_sample.over = o_sample.valid & i_over;
    o_sample.under = o_sample.valid & i_under;
  end
endmodule
`default_nettype wire

// ===== verification/afp_top_test.sv
// Self-checking bench for the output format and power block.
// Assumes the sampler model answers every start after four cycles.
`timescale 1ns/1ns
`default_nettype none
module afp_top_test;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata, rd, hi;
  afp_pkg::afp_sample_t smp;
  logic o_conv_start, o_amp_enable, o_adc_enable;
  logic [10:0] o_integration_cycles;
  logic [3:0] o_elem_count;
  logic [1:0] o_amp_bias_level, o_adc_bias_level;
  logic [15:0] m_value = 16'h0000;
  logic m_over = 1'b0;
  logic m_under = 1'b0;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;

  // 50 MHz clock
  always #10 i_mclk = ~i_mclk;

  afp_top afp_top_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_sample(smp), .o_conv_start(o_conv_start),
    .o_integration_cycles(o_integration_cycles),
    .o_elem_count(o_elem_count),
    .o_amp_bias_level(o_amp_bias_level),
    .o_adc_bias_level(o_adc_bias_level), .o_amp_enable(o_amp_enable),
    .o_adc_enable(o_adc_enable));
  afp_sampler_model afp_sampler_model_inst (.i_mclk(i_mclk),
    .i_rst(i_rst), .i_start(o_conv_start), .i_value(m_value),
    .i_over(m_over), .i_under(m_under), .o_sample(smp));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rdb(input logic [3:0] a);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 rd = o_rdata;
  endtask
  // Saturate, then force one-then-zeros below the resolution
  function automatic logic [15:0] fmt(input logic [2:0] o,
      input logic [1:0] e, input logic [15:0] v, input logic ov, un);
    int n;
    logic [15:0] w;
    w = ov ? 16'h7FFF : (un ? 16'h8000 : v);
    n = 2 * (3 + o) + e;
    if (n < 16) w = (w & ~((16'h1 << (16 - n)) - 16'h1)) | (16'h1 << (15 - n));
    return w;
  endfunction

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic test_reset;
    check(16'(o_integration_cycles), 16'h0008);
    check(16'(o_elem_count), 16'h0001);
    check(16'({o_amp_bias_level, o_adc_bias_level}), 16'h000F);
    check(16'({o_amp_enable, o_adc_enable}), 16'h0000);
  endtask
  task automatic test_config;
    for (int i = 0; i < 8; i++) begin
      wr(afp_pkg::ADDR_CONFIG, {1'b0, 2'(i % 4), 3'(i), 2'b00});
      #1 check(16'(o_integration_cycles), 16'(8 << i));
      check(16'(o_elem_count), 16'(1 << (i % 4)));
      rdb(afp_pkg::ADDR_CONFIG);
      check(16'(rd), 16'({1'b0, 2'(i % 4), 3'(i), 2'b00}));
    end
  endtask
  task automatic test_power;
    for (int b = 0; b < 4; b++) begin
      wr(afp_pkg::ADDR_POWER, {2'b00, 1'(b), ~1'(b), 2'(b), 2'(3 - b)});
      #1 check(16'(o_amp_bias_level), 16'(3 - b));
      check(16'(o_adc_bias_level), 16'(b));
      check(16'({o_adc_enable, o_amp_enable}), 16'({1'(b), ~1'(b)}));
      rdb(afp_pkg::ADDR_POWER);
      check(16'(rd), 16'({2'b00, 1'(b), ~1'(b), 2'(b), 2'(3 - b)}));
    end
  endtask
  task automatic test_conv(input logic [2:0] o, input logic [1:0] e,
      input logic [15:0] v, input logic ov, un, dflt);
    int k;
    m_value = v;
    m_over = ov;
    m_under = un;
    wr(afp_pkg::ADDR_CONFIG, {1'b0, e, o, 2'b00});
    wr(afp_pkg::ADDR_CONTROL, dflt ? 8'h02 : 8'h01);
    #1 check(16'(o_conv_start), 16'h0001);
    // Sampler answers later, so the first status read shows busy only
    rdb(afp_pkg::ADDR_STATUS);
    check(16'(rd), 16'h0001);
    rd = 8'h00;
    for (k = 0; k < 20 && rd[afp_pkg::STS_DONE_BIT] !== 1'b1; k++) begin
      rdb(afp_pkg::ADDR_STATUS);
    end
    check(16'(k < 20), 16'h0001);
    rdb(afp_pkg::ADDR_RESULT_HIGH);
    hi = rd;
    rdb(afp_pkg::ADDR_RESULT_LOW);
    check({hi, rd}, fmt(o, e, v, ov, un));
  endtask
  task automatic test_map;
    wr(afp_pkg::ADDR_RESULT_HIGH, 8'hAA);
    rdb(afp_pkg::ADDR_RESULT_HIGH);
    check(16'(rd), 16'h0012);
    rdb(4'hF);
    check(16'(rd), 16'h0000);
  endtask
  // Reset in mid-run brings back defaults and clears the result
  task automatic test_midrun_reset;
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    #1 test_reset();
    rdb(afp_pkg::ADDR_RESULT_HIGH);
    check(16'(rd), 16'h0000);
  endtask

  // Give up after a fixed number of cycles
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      stop_test;
    end
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    #1 test_reset();
    test_config();
    test_power();
    test_conv(3'h5, 2'h0, 16'hFFFF, 1'b0, 1'b0, 1'b0);
    test_conv(3'h5, 2'h1, 16'h1234, 1'b1, 1'b0, 1'b1);
    test_conv(3'h7, 2'h3, 16'h0055, 1'b0, 1'b1, 1'b0);
    test_conv(3'h0, 2'h0, 16'h5A5A, 1'b0, 1'b0, 1'b1);
    test_conv(3'h3, 2'h3, 16'h1234, 1'b0, 1'b0, 1'b0);
    test_conv(3'h4, 2'h0, 16'h8001, 1'b0, 1'b1, 1'b1);
    test_conv(3'h0, 2'h3, 16'h7FFF, 1'b0, 1'b0, 1'b0);
    test_conv(3'h7, 2'h0, 16'h8001, 1'b0, 1'b0, 1'b1);
    test_conv(3'h1, 2'h0, 16'h0000, 1'b1, 1'b0, 1'b0);
    test_conv(3'h5, 2'h0, 16'h1234, 1'b0, 1'b0, 1'b0);
    test_map();
    test_midrun_reset();
    stop_test();
  end
endmodule
`default_nettype wire
